//--- bcs_pkg.sv
package bcs_pkg;
	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_END_LIST    = 4'h0;
	localparam logic [3:0] OP_SKIP        = 4'h1;
	localparam logic [3:0] OP_GOTO        = 4'h2;
	localparam logic [3:0] OP_EXEC_BRANCH = 4'h5;
	localparam logic [3:0] OP_EXEC_COND   = 4'h6;
	localparam logic [3:0] OP_INT_CONT    = 4'hA;
	localparam logic [3:0] OP_CALL        = 4'hB;
	localparam logic [3:0] OP_RET_CALL    = 4'hC;
	localparam logic [3:0] OP_RESERVED    = 4'hD;
	localparam logic [3:0] OP_LOAD_MINOR  = 4'hE;
	localparam logic [3:0] OP_RET_BRANCH  = 4'hF;
	// ----------------------------------------------------------------
	// command block layout (word offsets from block start)
	// ----------------------------------------------------------------
	localparam logic [2:0] CB_CONTROL   = 3'h0;
	localparam logic [2:0] CB_CMD1      = 3'h1;
	localparam logic [2:0] CB_CMD2      = 3'h2;
	localparam logic [2:0] CB_DATA_PTR  = 3'h3;
	localparam logic [2:0] CB_STATUS1   = 3'h4;
	localparam logic [2:0] CB_STATUS2   = 3'h5;
	localparam logic [2:0] CB_BRANCH    = 3'h6;
	localparam logic [2:0] CB_TIMER     = 3'h7;
	localparam logic [3:0] CB_LENGTH    = 4'h8;
	localparam int         OPCODE_MSB   = 15;
	localparam int         OPCODE_LSB   = 12;
	localparam int         RTRT_BIT     = 8;
	// ----------------------------------------------------------------
	// pending interrupt bit positions and control bits
	// ----------------------------------------------------------------
	localparam int         PEND_ILLEGAL_BIT = 3;
	localparam int         PEND_EOL_BIT     = 5;
	localparam int         CTRL_STD_BIT     = 7;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         CLK_HZ           = 25000000;
	localparam int         MINOR_TICK_HZ    = 15625;
	localparam int         MINOR_TICK_DIV   = CLK_HZ / MINOR_TICK_HZ;
	localparam int         RESP_A_NS        = 9000;
	localparam int         RESP_A_CYC       = (RESP_A_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int         RESP_B_NS        = 14000;
	localparam int         RESP_B_CYC       = (RESP_B_NS * (CLK_HZ / 1000000)) / 1000;
	localparam logic [4:0] MODE_SA_ZERO     = 5'h00;
	localparam logic [4:0] MODE_SA_ONES     = 5'h1F;
endpackage

//--- bcs_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
module bcs_tick_div #(
	parameter int DIV = 1600
) (
	input  wire logic mclk,
	input  wire logic rstn,
	output var  logic tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	initial begin
		if (DIV < 2) $error("bcs_tick_div: DIV must be at least 2");
	end

	logic [CW-1:0] cnt_q;

	// free-running divider, one-cycle pulse at wrap
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q == CW'(DIV - 1)) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- bcs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module bcs_sequencer #(
	parameter int AW = 16,
	parameter int TW = 16
) (
	input  wire logic          mclk,
	input  wire logic          rstn,
	input  wire logic          start,
	input  wire logic [AW-1:0] listStart,
	input  wire logic          listEndIntEn,
	input  wire logic          illegalIntEn,
	input  wire logic          standard_select_input,
	input  wire logic          standard_select_bit,
	input  wire logic          useExtTimerClk,
	input  wire logic          external_timer_clock,
	output logic               memRd,
	output logic               memWr,
	output logic [AW-1:0]      memAddr,
	output logic [15:0]        memWdata,
	input  wire logic          memAck,
	input  wire logic [15:0]   memRdata,
	output logic               msgStart,
	output logic [15:0]        msgCmd1,
	output logic [15:0]        msgCmd2,
	output logic               msgRtRt,
	output logic [AW-1:0]      msgDataPtr,
	output logic               msgModeCode,
	output logic               msgNoData,
	output logic [15:0]        respTimeoutCyc,
	input  wire logic          msgDone,
	input  wire logic          msgCondMet,
	input  wire logic [15:0]   msgStatusTx,
	input  wire logic [15:0]   msgStatusRx,
	output logic               busy,
	output logic               list_end_interrupt,
	output logic               intContinue,
	output logic               illegalPending,
	output logic               modeA
);
	initial begin
		if (AW < 4 || AW > 16) $error("bcs_sequencer: AW must be 4..16");
		if (TW < 2 || TW > 16) $error("bcs_sequencer: TW must be 2..16");
	end

	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	typedef enum {
		S_IDLE, S_FETCH, S_DECODE, S_MSG, S_WAIT_MSG, S_ST1, S_ST2, S_SKIP, S_MINOR
	} bcs_state_t;

	bcs_state_t    state_q;
	logic [2:0]    idx_q;
	logic [15:0]   cbw_q [0:7];
	logic [AW-1:0] cbBase_q;
	logic [AW-1:0] callRet_q;
	logic [AW-1:0] branchRet_q;
	logic [TW-1:0] msgTmr_q;
	logic [TW-1:0] minorTmr_q;
	logic          minorLoad;
	logic          extClkD_q;
	logic          extEdge;
	logic          minorTick;
	logic [AW-1:0] nextBase;
	logic [3:0]    opcode;
	logic          cmdIsMode;
	logic [15:0]   stRx_q;

	localparam logic [2:0] CB_CONTROL = bcs_pkg::CB_CONTROL;
	localparam logic [2:0] CB_TIMER   = bcs_pkg::CB_TIMER;

	assign opcode   = cbw_q[CB_CONTROL][bcs_pkg::OPCODE_MSB:bcs_pkg::OPCODE_LSB];
	assign nextBase = cbBase_q + AW'(bcs_pkg::CB_LENGTH);

	// ----------------------------------------------------------------
	// protocol selection
	// ----------------------------------------------------------------
	// either the pin or the control bit selects the older standard
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			modeA          <= 1'b0;
			respTimeoutCyc <= 16'h0000;
		end else begin
			modeA          <= standard_select_input | standard_select_bit;
			respTimeoutCyc <= (standard_select_input | standard_select_bit) ?
				16'(bcs_pkg::RESP_A_CYC) : 16'(bcs_pkg::RESP_B_CYC);
		end
	end

	// mode code decode: subaddress 0 is a mode code, 31 only under revision B
	assign cmdIsMode = (cbw_q[bcs_pkg::CB_CMD1][9:5] == bcs_pkg::MODE_SA_ZERO) ||
		(!modeA && cbw_q[bcs_pkg::CB_CMD1][9:5] == bcs_pkg::MODE_SA_ONES);

	// ----------------------------------------------------------------
	// minor frame timer clock source
	// ----------------------------------------------------------------
	bcs_tick_div #(
		.DIV (bcs_pkg::MINOR_TICK_DIV)
	) uTick (
		.mclk (mclk),
		.rstn (rstn),
		.tick (minorTick)
	);

	// edge detect on the external timer clock (pin is synchronous)
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			extClkD_q <= 1'b0;
		end else begin
			extClkD_q <= external_timer_clock;
		end
	end
	assign extEdge = external_timer_clock & ~extClkD_q;

	// free-running minor frame down counter, stops at zero until reloaded
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			minorTmr_q <= '0;
		end else if (minorLoad) begin
			minorTmr_q <= cbw_q[CB_TIMER][TW-1:0];
		end else if ((useExtTimerClk ? extEdge : minorTick) && minorTmr_q != '0) begin
			minorTmr_q <= minorTmr_q - 1'b1;
		end
	end
	assign minorLoad = (state_q == S_MINOR) && (minorTmr_q == '0);

	// message-to-message timer on the core clock
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			msgTmr_q <= '0;
		end else if (state_q == S_DECODE && opcode == bcs_pkg::OP_SKIP) begin
			msgTmr_q <= cbw_q[CB_TIMER][TW-1:0];
		end else if (msgTmr_q != '0) begin
			msgTmr_q <= msgTmr_q - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// command block fetch buffer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (state_q == S_FETCH && memRd && memAck) begin
			cbw_q[idx_q] <= memRdata;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q            <= S_IDLE;
			idx_q              <= 3'h0;
			cbBase_q           <= '0;
			callRet_q          <= '0;
			branchRet_q        <= '0;
			stRx_q             <= 16'h0000;
			memRd              <= 1'b0;
			memWr              <= 1'b0;
			memAddr            <= '0;
			memWdata           <= 16'h0000;
			msgStart           <= 1'b0;
			msgCmd1            <= 16'h0000;
			msgCmd2            <= 16'h0000;
			msgRtRt            <= 1'b0;
			msgDataPtr         <= '0;
			msgModeCode        <= 1'b0;
			msgNoData          <= 1'b0;
			busy               <= 1'b0;
			list_end_interrupt <= 1'b0;
			intContinue        <= 1'b0;
			illegalPending     <= 1'b0;
		end else begin
			msgStart           <= 1'b0;
			list_end_interrupt <= 1'b0;
			intContinue        <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (start) begin
						cbBase_q       <= listStart;
						memAddr        <= listStart;
						memRd          <= 1'b1;
						idx_q          <= 3'h0;
						busy           <= 1'b1;
						illegalPending <= 1'b0;
						state_q        <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (memAck) begin
						if (idx_q == 3'h7) begin
							memRd   <= 1'b0;
							state_q <= S_DECODE;
						end else begin
							idx_q   <= idx_q + 3'h1;
							memAddr <= cbBase_q + AW'(idx_q) + AW'(1);
						end
					end
				end
				S_DECODE: begin
					case (opcode)
						bcs_pkg::OP_END_LIST: begin
							list_end_interrupt <= listEndIntEn;
							busy               <= 1'b0;
							state_q            <= S_IDLE;
						end
						bcs_pkg::OP_SKIP: begin
							state_q <= S_SKIP;
						end
						bcs_pkg::OP_GOTO: begin
							cbBase_q <= cbw_q[bcs_pkg::CB_BRANCH][AW-1:0];
							state_q  <= S_FETCH;
						end
						bcs_pkg::OP_INT_CONT: begin
							intContinue <= 1'b1;
							cbBase_q    <= nextBase;
							state_q     <= S_FETCH;
						end
						bcs_pkg::OP_CALL: begin
							callRet_q <= nextBase;
							cbBase_q  <= cbw_q[bcs_pkg::CB_BRANCH][AW-1:0];
							state_q   <= S_FETCH;
						end
						bcs_pkg::OP_RET_CALL: begin
							cbBase_q <= callRet_q;
							state_q  <= S_FETCH;
						end
						bcs_pkg::OP_RESERVED: begin
							illegalPending <= illegalIntEn;
							busy           <= 1'b0;
							state_q        <= S_IDLE;
						end
						bcs_pkg::OP_LOAD_MINOR: begin
							state_q <= S_MINOR;
						end
						bcs_pkg::OP_RET_BRANCH: begin
							cbBase_q <= branchRet_q;
							state_q  <= S_FETCH;
						end
						default: begin
							state_q <= S_MSG; // execute-class opcodes
						end
					endcase
					// every redirect refetches the new block from word 0
					idx_q <= 3'h0;
					case (opcode)
						bcs_pkg::OP_GOTO: begin
							memAddr <= cbw_q[bcs_pkg::CB_BRANCH][AW-1:0];
							memRd   <= 1'b1;
						end
						bcs_pkg::OP_CALL: begin
							memAddr <= cbw_q[bcs_pkg::CB_BRANCH][AW-1:0];
							memRd   <= 1'b1;
						end
						bcs_pkg::OP_INT_CONT: begin
							memAddr <= nextBase;
							memRd   <= 1'b1;
						end
						bcs_pkg::OP_RET_CALL: begin
							memAddr <= callRet_q;
							memRd   <= 1'b1;
						end
						bcs_pkg::OP_RET_BRANCH: begin
							memAddr <= branchRet_q;
							memRd   <= 1'b1;
						end
						default: begin
							memRd <= 1'b0;
						end
					endcase
				end
				S_MSG: begin
					msgStart    <= 1'b1;
					msgCmd1     <= cbw_q[bcs_pkg::CB_CMD1];
					msgCmd2     <= cbw_q[bcs_pkg::CB_CMD2];
					msgRtRt     <= cbw_q[CB_CONTROL][bcs_pkg::RTRT_BIT];
					msgDataPtr  <= cbw_q[bcs_pkg::CB_DATA_PTR][AW-1:0];
					msgModeCode <= cmdIsMode;
					msgNoData   <= cmdIsMode && modeA;
					state_q     <= S_WAIT_MSG;
				end
				S_WAIT_MSG: begin
					if (msgDone) begin
						memWr    <= 1'b1;
						memAddr  <= cbBase_q + AW'(bcs_pkg::CB_STATUS1);
						memWdata <= msgStatusTx;
						stRx_q   <= msgStatusRx; // receiver status only valid with done
						// save return point before a taken branch
						if (opcode == bcs_pkg::OP_EXEC_BRANCH ||
							(opcode == bcs_pkg::OP_EXEC_COND && msgCondMet)) begin
							branchRet_q <= nextBase;
							cbBase_q    <= cbw_q[bcs_pkg::CB_BRANCH][AW-1:0];
						end else begin
							cbBase_q    <= nextBase;
						end
						state_q  <= S_ST1;
					end
				end
				S_ST1: begin
					if (memAck) begin
						memAddr  <= memAddr + AW'(1);
						memWdata <= stRx_q;
						state_q  <= S_ST2;
					end
				end
				S_ST2: begin
					if (memAck) begin
						memWr   <= 1'b0;
						memRd   <= 1'b1;
						memAddr <= cbBase_q;
						idx_q   <= 3'h0;
						state_q <= S_FETCH;
					end
				end
				S_SKIP: begin
					if (msgTmr_q == '0) begin
						cbBase_q <= nextBase;
						memAddr  <= nextBase;
						memRd    <= 1'b1;
						idx_q    <= 3'h0;
						state_q  <= S_FETCH;
					end
				end
				S_MINOR: begin
					if (minorLoad) begin
						cbBase_q <= nextBase;
						memAddr  <= nextBase;
						memRd    <= 1'b1;
						idx_q    <= 3'h0;
						state_q  <= S_FETCH;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- bcs_sequencer_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// sequencer port checker
// ----------------------------------------------------------------
module bcs_sequencer_sva #(
	parameter int AW = 16
) (
	input wire logic          mclk,
	input wire logic          rstn,
	input wire logic          start,
	input wire logic [AW-1:0] listStart,
	input wire logic          listEndIntEn,
	input wire logic          illegalIntEn,
	input wire logic          standard_select_input,
	input wire logic          standard_select_bit,
	input wire logic          memRd,
	input wire logic          memWr,
	input wire logic [AW-1:0] memAddr,
	input wire logic [15:0]   memWdata,
	input wire logic          memAck,
	input wire logic          msgStart,
	input wire logic [15:0]   msgCmd1,
	input wire logic          msgRtRt,
	input wire logic          msgModeCode,
	input wire logic          msgNoData,
	input wire logic [15:0]   respTimeoutCyc,
	input wire logic          busy,
	input wire logic          list_end_interrupt,
	input wire logic          intContinue,
	input wire logic          illegalPending,
	input wire logic          modeA
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rstn);
	// start taken in idle, first fetch at the list base
	busy_take_a: assert property (!busy && start |=> busy)
		else $error("start in idle not taken");
	fetch_base_a: assert property ($rose(busy) |-> memRd && memAddr == $past(listStart))
		else $error("first fetch address wrong");
	// memory requests hold until acknowledged
	rd_hold_a: assert property (memRd && !memAck |=> memRd && $stable(memAddr))
		else $error("read request not held");
	wr_hold_a: assert property (memWr && !memAck |=> memWr && $stable(memAddr) && $stable(memWdata))
		else $error("write request not held");
	// list end, continue and illegal opcode events
	eol_pulse_a: assert property (list_end_interrupt |-> listEndIntEn && !busy ##1 !list_end_interrupt)
		else $error("list end pulse wrong");
	int_cont_a: assert property (intContinue |-> memRd && !msgStart ##1 !intContinue)
		else $error("continue pulse wrong");
	illegal_stop_a: assert property ($rose(illegalPending) |-> illegalIntEn ##[0:2] !busy)
		else $error("illegal opcode did not stop");
	// protocol revision and message attributes
	std_a_sel_a: assert property ((standard_select_input || standard_select_bit) [*2] |-> modeA)
		else $error("revision A not selected");
	std_b_sel_a: assert property ((!standard_select_input && !standard_select_bit) [*2] |-> !modeA)
		else $error("revision B not selected");
	resp_time_a: assert property (msgStart |-> respTimeoutCyc ==
		(modeA ? 16'(bcs_pkg::RESP_A_CYC) : 16'(bcs_pkg::RESP_B_CYC)))
		else $error("response timeout wrong");
	mode_sa_a: assert property (msgStart && modeA && !msgRtRt |->
		msgModeCode == (msgCmd1[9:5] == bcs_pkg::MODE_SA_ZERO))
		else $error("mode code decode wrong");
	no_data_a: assert property (msgStart && modeA && msgModeCode |-> msgNoData)
		else $error("mode code carries data");
	msg_pulse_a: assert property (msgStart |-> busy ##1 !msgStart)
		else $error("message start pulse wrong");
endmodule

bind bcs_sequencer bcs_sequencer_sva #(.AW(AW)) u_sva (
	.mclk(mclk), .rstn(rstn), .start(start), .listStart(listStart),
	.listEndIntEn(listEndIntEn), .illegalIntEn(illegalIntEn),
	.standard_select_input(standard_select_input), .standard_select_bit(standard_select_bit),
	.memRd(memRd), .memWr(memWr), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
	.msgStart(msgStart), .msgCmd1(msgCmd1), .msgRtRt(msgRtRt), .msgModeCode(msgModeCode),
	.msgNoData(msgNoData), .respTimeoutCyc(respTimeoutCyc), .busy(busy),
	.list_end_interrupt(list_end_interrupt), .intContinue(intContinue),
	.illegalPending(illegalPending), .modeA(modeA)
);
`default_nettype wire

//--- bcs_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// list memory and remote terminal model
// ----------------------------------------------------------------
module bcs_bus_model (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        stall,
	input  wire logic        memRd,
	input  wire logic        memWr,
	input  wire logic [15:0] memAddr,
	input  wire logic [15:0] memWdata,
	output var  logic        memAck,
	output var  logic [15:0] memRdata,
	input  wire logic        msgStart,
	input  wire logic [15:0] statTx,
	input  wire logic [15:0] statRx,
	output var  logic        msgDone,
	output var  logic        msgCondMet,
	output var  logic [15:0] msgStatusTx,
	output var  logic [15:0] msgStatusRx
);
	logic [15:0] mem [0:255];
	logic [3:0]  msgCnt;
	logic        take;
	// one word per acknowledge, random stalls slow the answer
	assign take = (memRd || memWr) && !memAck && !stall;
	// read data only valid with acknowledge, toggles otherwise
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			memAck   <= 1'b0;
			memRdata <= 16'h0000;
		end else begin
			memAck   <= take;
			memRdata <= take ? mem[memAddr[7:0]] : ~memRdata;
			if (memWr && memAck)
				mem[memAddr[7:0]] <= memWdata;
		end
	end
	// terminals answer a fixed time after message start
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			msgCnt      <= 4'h0;
			msgDone     <= 1'b0;
			msgCondMet  <= 1'b0;
			msgStatusTx <= 16'h0000;
			msgStatusRx <= 16'h0000;
		end else begin
			msgDone     <= (msgCnt == 4'h1);
			msgCnt      <= msgStart ? 4'h6 : ((msgCnt != 4'h0) ? msgCnt - 4'h1 : 4'h0);
			msgStatusTx <= (msgCnt == 4'h1) ? statTx : ~msgStatusTx;
			msgStatusRx <= (msgCnt == 4'h1) ? statRx : ~msgStatusRx;
		end
	end
endmodule
`default_nettype wire

//--- bc_command_block_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module bc_command_block_sequencer_bench;
	logic        mclk, rstn, start, listEndIntEn, illegalIntEn, extClk, stall, illPrev;
	logic        standard_select_input, standard_select_bit, memRd, memWr, memAck;
	logic        msgStart, msgRtRt, msgModeCode, msgNoData, msgDone, msgCondMet, busy;
	logic        list_end_interrupt, intContinue, illegalPending, modeA, useExt;
	logic [15:0] listStart, memAddr, memWdata, memRdata, msgCmd1, msgCmd2, msgDataPtr;
	logic [15:0] respTimeoutCyc, msgStatusTx, msgStatusRx, statTx, statRx;
	logic [63:0] expQ [$];
	int          err_count, samples_checked, seed, i;

	// ----------------------------------------------------------------
	// clock, design and far side
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	bcs_sequencer u_dut (.mclk(mclk), .rstn(rstn), .start(start), .listStart(listStart),
		.listEndIntEn(listEndIntEn), .illegalIntEn(illegalIntEn),
		.standard_select_input(standard_select_input), .standard_select_bit(standard_select_bit),
		.useExtTimerClk(useExt), .external_timer_clock(extClk), .memRd(memRd), .memWr(memWr),
		.memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
		.msgStart(msgStart), .msgCmd1(msgCmd1), .msgCmd2(msgCmd2), .msgRtRt(msgRtRt),
		.msgDataPtr(msgDataPtr), .msgModeCode(msgModeCode), .msgNoData(msgNoData),
		.respTimeoutCyc(respTimeoutCyc), .msgDone(msgDone), .msgCondMet(msgCondMet),
		.msgStatusTx(msgStatusTx), .msgStatusRx(msgStatusRx), .busy(busy),
		.list_end_interrupt(list_end_interrupt), .intContinue(intContinue),
		.illegalPending(illegalPending), .modeA(modeA));
	bcs_bus_model u_mem (.mclk(mclk), .rstn(rstn), .stall(stall), .memRd(memRd),
		.memWr(memWr), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
		.memRdata(memRdata), .msgStart(msgStart), .statTx(statTx), .statRx(statRx),
		.msgDone(msgDone), .msgCondMet(msgCondMet), .msgStatusTx(msgStatusTx),
		.msgStatusRx(msgStatusRx));

	// ----------------------------------------------------------------
	// checking and notes
	// ----------------------------------------------------------------
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic take(input logic [63:0] got);
		if (expQ.size() == 0)
			cmp(got, 64'h0);
		else
			cmp(got, expQ.pop_front());
	endtask
	// block image in memory plus the note of its fetch
	task automatic blk(input logic [7:0] a, input logic [15:0] c, w1, w2, dp, br, tm);
		logic [15:0] w [8];
		w = '{c, w1, w2, dp, 16'hFFFF, 16'hFFFF, br, tm};
		for (int k = 0; k < 8; k++)
			u_mem.mem[a + 8'(k)] = w[k];
		expQ.push_back({4'h1, 44'h0, 8'h00, a});
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		expQ.push_back({4'h2, 28'h0, 8'h00, a, d});
	endtask
	task automatic end_sim();
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// start a list and wait for it to stop
	task automatic run(input logic [7:0] a);
		@(posedge mclk);
		#2 start = 1'b1;
		listStart = {8'h00, a};
		@(posedge mclk);
		#2 start = 1'b0;
		for (i = 0; i < 4000 && busy !== 1'b0; i++) begin
			@(posedge mclk);
			#2;
		end
		if (i == 4000) begin
			err_count++;
			end_sim();
		end
		repeat (2) @(posedge mclk);
		cmp({32'h0, expQ.size()}, 64'h0);
	endtask
	// observer: every result takes the oldest note
	always @(posedge mclk) begin
		if (rstn) begin
			if (memRd && memAck && memAddr[2:0] == 3'h0) take({4'h1, 44'h0, memAddr});
			if (memWr && memAck) take({4'h2, 28'h0, memAddr, memWdata});
			if (msgStart) take({4'h3, msgRtRt, msgModeCode, msgNoData, 1'b0, msgDataPtr[7:0],
				msgCmd1, msgCmd2, respTimeoutCyc});
			if (intContinue) take({4'h4, 60'h0});
			if (list_end_interrupt) take({4'h5, 60'h0});
			if (illegalPending && !illPrev) take({4'h6, 60'h0});
		end
		illPrev = illegalPending;
	end
	// random memory stalls and a free timer clock
	initial begin
		stall = 1'b0;
		extClk = 1'b0;
		forever begin
			@(posedge mclk);
			#2 stall = 1'($random(seed));
			extClk = ~extClk;
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 18;
		{err_count, samples_checked} = '0;
		{rstn, start, standard_select_input, standard_select_bit, illPrev} = '0;
		{listEndIntEn, illegalIntEn, listStart} = {2'b11, 16'h0000};
		useExt = 1'b1;
		statTx = 16'($random(seed));
		statRx = 16'($random(seed));
		repeat (4) @(posedge mclk);
		#2 rstn = 1'b1;
		// revision B: continue, call, branch message, skip, returns, frame timer, end
		blk(8'h10, 16'hA000, 0, 0, 0, 0, 0);
		expQ.push_back({4'h4, 60'h0});
		blk(8'h18, 16'hB000, 0, 0, 0, 16'h0040, 0);
		blk(8'h40, 16'h5100, 16'h0843, 16'h1443, 16'h00A0, 16'h0060, 0);
		expQ.push_back({8'h38, 8'hA0, 16'h0843, 16'h1443, 16'(bcs_pkg::RESP_B_CYC)});
		wr(8'h44, statTx);
		wr(8'h45, statRx);
		blk(8'h60, 16'h1000, 0, 0, 0, 0, 16'h0005);
		blk(8'h68, 16'hF000, 0, 0, 0, 0, 0);
		blk(8'h48, 16'hC000, 0, 0, 0, 0, 0);
		blk(8'h20, 16'hE000, 0, 0, 0, 0, 16'h0003);
		blk(8'h28, 16'hE000, 0, 0, 0, 0, 16'h0002);
		blk(8'h30, 16'h0000, 0, 0, 0, 0, 0);
		expQ.push_back({4'h5, 60'h0});
		run(8'h10);
		// revision A by input: mode code message, then reserved opcode
		standard_select_input = 1'b1;
		statTx = 16'($random(seed));
		statRx = 16'($random(seed));
		blk(8'h80, 16'h4000, 16'h1C02, 16'h0000, 16'h00B0, 0, 0);
		expQ.push_back({8'h36, 8'hB0, 16'h1C02, 16'h0000, 16'(bcs_pkg::RESP_A_CYC)});
		wr(8'h84, statTx);
		wr(8'h85, statRx);
		blk(8'h88, 16'hD000, 0, 0, 0, 0, 0);
		expQ.push_back({4'h6, 60'h0});
		run(8'h80);
		cmp({63'h0, illegalPending}, 64'h1);
		// revision A by control bit, list end interrupt disabled
		{standard_select_input, standard_select_bit, listEndIntEn} = 3'b010;
		blk(8'h30, 16'h0000, 0, 0, 0, 0, 0);
		run(8'h30);
		cmp({63'h0, illegalPending}, 64'h0);
		cmp({63'h0, modeA}, 64'h1);
		// minor frame timer on the internal tick
		useExt = 1'b0;
		blk(8'hC0, 16'hE000, 0, 0, 0, 0, 16'h0001);
		blk(8'hC8, 16'hE000, 0, 0, 0, 0, 16'h0001);
		blk(8'hD0, 16'h0000, 0, 0, 0, 0, 0);
		run(8'hC0);
		end_sim();
	end
endmodule
`default_nettype wire
